// ===== logic/pfr_map.vh
// Register map, field positions and reset values of the peripheral flag block
`ifndef PFR_MAP_VH
`define PFR_MAP_VH
`define PFR_ADDR_FLAGS 12'h000
`define PFR_ADDR_ENABLE 12'h004
`define PFR_ADDR_CTRL 12'h008
`define PFR_ADDR_IRQ_STATUS 12'h00c
`define PFR_ADDR_IRQ_MASK 12'h010
`define PFR_BIT_TIMER_A 0
`define PFR_BIT_TIMER_B 1
`define PFR_BIT_CAPCOMP 2
`define PFR_BIT_SYNC 3
`define PFR_BIT_TX 4
`define PFR_BIT_RX 5
`define PFR_BIT_CONV 6
`define PFR_BIT_GIE 7
`define PFR_FLAGS_RESET 8'h00
`define PFR_SW_CLEAR_MASK 8'h4f
`define PFR_IMPL_MASK 8'h7f
`define PFR_ENABLE_RESET 8'h00
`define PFR_CTRL_RESET 8'h00
`define PFR_MASK_RESET 8'h00
`endif

// ===== logic/pfr_sync.v
// Two flip-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module pfr_sync #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   always @(posedge clk) begin
      if (!reset_n) begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== logic/pfr_sticky.v
// Sticky event flag where a set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module pfr_sticky #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] set,
   input wire [WIDTH-1:0] clear,
   output reg [WIDTH-1:0] flag_q
);
   always @(posedge clk) begin
      if (!reset_n) begin
         flag_q <= {WIDTH{1'b0}};
      end else begin
         // Set wins so an event landing on the clear cycle is kept
         flag_q <= set | (flag_q & ~clear);
      end
   end
endmodule
`default_nettype wire

// ===== logic/pfr_flag_reg.v
// Peripheral interrupt request flag register 1 with APB access
//
// What this block does
// - Each flag is set by its event whatever the source enables and the global enable at control bit 7 say.
// - Bit 7 of the flag register is unimplemented and always reads zero.
// - Bit 6 sets on a finished conversion and stays set until software clears it.
// - Bit 5 follows the receive buffer being full, clears when that buffer is read, and ignores writes.
// - Bit 3 sets when a synchronous serial transfer completes and stays set until software clears it.
// - Bit 2 sets on a capture or a compare match of unit 1 and stays set until software clears it.
// - Bit 1 sets when timer B matches its period and stays set until software clears it.
// - Bit 0 reads zero while no timer A overflow has happened since the last clear.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pfr_map.vh"
module pfr_flag_reg (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire conv_done,
   input wire rx_buffer_full,
   input wire tx_buffer_empty,
   input wire sync_serial_done,
   input wire capcomp_event,
   input wire timer_b_match,
   input wire timer_a_overflow,
   output wire [7:0] flag_out,
   output wire peripheral_irq,
   output wire irq_out
);
   // Event pulses and levels come from peripheral logic on clk; the buffer
   // levels are treated as pins and pass the synchroniser
   wire [1:0] buf_sync;
   reg [1:0] buf_q;
   wire [7:0] flag_q;
   reg [7:0] flag_set;
   reg [7:0] flag_clr;
   reg [7:0] enable_q;
   reg [7:0] ctrl_q;
   wire [7:0] irq_status_q;
   reg [7:0] irq_mask_q;
   reg [7:0] flag_prev_q;
   reg [7:0] status_clr;
   reg [7:0] read_mux;
   reg addr_ok;
   wire setup_ok;
   wire wr_acc;
   wire rd_acc;

   function [7:0] pfr_wmask;
      input [7:0] data;
      input [7:0] mask;
      begin
         pfr_wmask = data & mask;
      end
   endfunction

   pfr_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in({rx_buffer_full, tx_buffer_empty}),
      .sync_out(buf_sync)
   );

   always @(posedge clk) begin
      if (!reset_n) begin
         buf_q <= 2'h0;
      end else begin
         buf_q <= buf_sync;
      end
   end

   assign setup_ok = psel & penable;
   assign wr_acc = setup_ok & pwrite & pstrb[0];
   assign rd_acc = setup_ok & ~pwrite;

   always @* begin
      addr_ok = 1'b0;
      if (paddr == `PFR_ADDR_FLAGS) begin
         addr_ok = 1'b1;
      end else if (paddr == `PFR_ADDR_ENABLE) begin
         addr_ok = 1'b1;
      end else if (paddr == `PFR_ADDR_CTRL) begin
         addr_ok = 1'b1;
      end else if (paddr == `PFR_ADDR_IRQ_STATUS) begin
         addr_ok = 1'b1;
      end else if (paddr == `PFR_ADDR_IRQ_MASK) begin
         addr_ok = 1'b1;
      end
   end

   assign pready = 1'b1;
   assign pslverr = setup_ok & ~addr_ok;

   // Flag set and clear terms; enables never gate a set
   always @* begin
      flag_set = 8'h00;
      flag_clr = 8'h00;
      flag_set[`PFR_BIT_CONV] = conv_done;
      flag_set[`PFR_BIT_SYNC] = sync_serial_done;
      flag_set[`PFR_BIT_CAPCOMP] = capcomp_event;
      flag_set[`PFR_BIT_TIMER_B] = timer_b_match;
      flag_set[`PFR_BIT_TIMER_A] = timer_a_overflow;
      // Software writes only clear; writing one to a sticky flag is left out
      // so a test cannot fake an event
      if (wr_acc && paddr == `PFR_ADDR_FLAGS) begin
         flag_clr = pfr_wmask(~pwdata[7:0], `PFR_SW_CLEAR_MASK);
      end
      // Buffer flags are levels, not sticky: they follow the buffer state
      flag_set[`PFR_BIT_RX] = buf_q[1];
      flag_set[`PFR_BIT_TX] = buf_q[0];
      flag_clr[`PFR_BIT_RX] = ~buf_q[1];
      flag_clr[`PFR_BIT_TX] = ~buf_q[0];
   end

   pfr_sticky #(
      .WIDTH(7)
   ) u_flags (
      .clk(clk),
      .reset_n(reset_n),
      .set(flag_set[6:0]),
      .clear(flag_clr[6:0]),
      .flag_q(flag_q[6:0])
   );

   assign flag_q[7] = 1'b0;
   assign flag_out = flag_q;

   always @(posedge clk) begin
      if (!reset_n) begin
         enable_q <= `PFR_ENABLE_RESET;
         ctrl_q <= `PFR_CTRL_RESET;
         irq_mask_q <= `PFR_MASK_RESET;
      end else if (wr_acc) begin
         if (paddr == `PFR_ADDR_ENABLE) begin
            enable_q <= pfr_wmask(pwdata[7:0], `PFR_IMPL_MASK);
         end else if (paddr == `PFR_ADDR_CTRL) begin
            ctrl_q <= pwdata[7:0];
         end else if (paddr == `PFR_ADDR_IRQ_MASK) begin
            irq_mask_q <= pfr_wmask(pwdata[7:0], `PFR_IMPL_MASK);
         end
      end
   end

   // Request to the core only gated here; flags themselves are ungated
   assign peripheral_irq = ctrl_q[`PFR_BIT_GIE] & |(flag_q & enable_q);

   // Status records rising edges of flags; read of the status clears it
   always @(posedge clk) begin
      if (!reset_n) begin
         flag_prev_q <= `PFR_FLAGS_RESET;
      end else begin
         flag_prev_q <= flag_q;
      end
   end

   // Clear only what the read reported in prdata at setup; an edge that lands
   // in the access phase stays pending instead of being lost
   always @* begin
      status_clr = 8'h00;
      if (rd_acc && paddr == `PFR_ADDR_IRQ_STATUS) begin
         status_clr = prdata[7:0];
      end
   end

   pfr_sticky #(
      .WIDTH(8)
   ) u_status (
      .clk(clk),
      .reset_n(reset_n),
      .set(flag_q & ~flag_prev_q),
      .clear(status_clr),
      .flag_q(irq_status_q)
   );

   assign irq_out = |(irq_status_q & irq_mask_q);

   always @* begin
      read_mux = 8'h00;
      if (paddr == `PFR_ADDR_FLAGS) begin
         read_mux = flag_q;
      end else if (paddr == `PFR_ADDR_ENABLE) begin
         read_mux = enable_q;
      end else if (paddr == `PFR_ADDR_CTRL) begin
         read_mux = ctrl_q;
      end else if (paddr == `PFR_ADDR_IRQ_STATUS) begin
         read_mux = irq_status_q;
      end else if (paddr == `PFR_ADDR_IRQ_MASK) begin
         read_mux = irq_mask_q;
      end
   end

   // Read data registered on the setup cycle so it is stable in the access phase
   always @(posedge clk) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, read_mux};
      end
   end
endmodule
`default_nettype wire

// ===== verif/pfr_flag_reg_monitor.sv
// Port checks of the peripheral flag register
`timescale 1ns/1ps
`default_nettype none
module pfr_flag_reg_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [7:0] flag_out,
   input wire logic conv_done,
   input wire logic sync_serial_done,
   input wire logic capcomp_event,
   input wire logic timer_b_match,
   input wire logic timer_a_overflow,
   input wire logic rx_buffer_full,
   input wire logic tx_buffer_empty
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_bit7_zero: assert property (flag_out[7] == 1'b0) else $error("bit 7 set");
   a_conv_set: assert property (conv_done |=> flag_out[6]) else $error("conv flag");
   a_sync_set: assert property (sync_serial_done |=> flag_out[3]) else $error("sync flag");
   a_capcomp_set: assert property (capcomp_event |=> flag_out[2]) else $error("capcomp flag");
   a_timer_b_set: assert property (timer_b_match |=> flag_out[1]) else $error("timer b flag");
   a_timer_a_set: assert property (timer_a_overflow |=> flag_out[0]) else $error("timer a flag");
   // Sticky bits may only fall after a write to the flag register
   a_sticky_hold: assert property (|($past(flag_out) & ~flag_out & 8'h4f)
      |-> $past(psel && penable && pwrite && paddr == 12'h000)) else $error("flag lost");
   a_rx_follow: assert property (rx_buffer_full [*6] |-> flag_out[5]) else $error("rx flag");
   a_tx_follow: assert property (tx_buffer_empty [*6] |-> flag_out[4]) else $error("tx flag");
   a_rx_clear: assert property (!rx_buffer_full [*6] |-> !flag_out[5]) else $error("rx flag stuck");
   a_tx_clear: assert property (!tx_buffer_empty [*6] |-> !flag_out[4]) else $error("tx flag stuck");
   cover property (timer_a_overflow && psel && penable && pwrite);
   cover property ($rose(flag_out[5]));
   cover property ($fell(flag_out[6]));
endmodule
`default_nettype wire

// ===== verif/pfr_event_src.sv
// Model of the peripheral event sources
`timescale 1ns/1ps
`default_nettype none
module pfr_event_src (
   input wire logic clk,
   input wire logic [6:0] fire,
   output wire logic conv_done,
   output wire logic sync_serial_done,
   output wire logic capcomp_event,
   output wire logic timer_b_match,
   output wire logic timer_a_overflow,
   output wire logic rx_buffer_full,
   output wire logic tx_buffer_empty
);
   // Registered so a pulse lasts exactly one clock, as from a real timer
   logic [6:0] q = 7'h00;
   always @(posedge clk) q <= fire;
   assign {tx_buffer_empty, rx_buffer_full, conv_done, sync_serial_done} = q[6:3];
   assign {capcomp_event, timer_b_match, timer_a_overflow} = q[2:0];
endmodule
`default_nettype wire

// ===== verif/pfr_flag_reg_tb.sv
// Self-checking bench of the peripheral flag register
`timescale 1ns/1ps
`default_nettype none
module pfr_flag_reg_tb;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] pstrb = 4'hf;
   logic [6:0] fire = 7'h00, f;
   logic [7:0] flag_out, exp, d;
   logic pready, pslverr, serr, peripheral_irq, irq_out, conv_done, sync_serial_done;
   logic capcomp_event, timer_b_match, timer_a_overflow, rx_buffer_full, tx_buffer_empty;
   integer num_errors = 0, cmp_count = 0, seed = 39129, cyc = 0, i;
   pfr_event_src src (
      .clk(clk),
      .fire(fire),
      .conv_done(conv_done),
      .sync_serial_done(sync_serial_done),
      .capcomp_event(capcomp_event),
      .timer_b_match(timer_b_match),
      .timer_a_overflow(timer_a_overflow),
      .rx_buffer_full(rx_buffer_full),
      .tx_buffer_empty(tx_buffer_empty)
   );
   pfr_flag_reg dut (
      .clk(clk),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .conv_done(conv_done),
      .rx_buffer_full(rx_buffer_full),
      .tx_buffer_empty(tx_buffer_empty),
      .sync_serial_done(sync_serial_done),
      .capcomp_event(capcomp_event),
      .timer_b_match(timer_b_match),
      .timer_a_overflow(timer_a_overflow),
      .flag_out(flag_out),
      .peripheral_irq(peripheral_irq),
      .irq_out(irq_out)
   );
   always #50 clk = ~clk;
   task end_sim;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count = cmp_count + 1;
      if (got !== want) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, v};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bits 6 and 5 are levels that stay, the rest are one-clock pulses
   task fire_ev(input logic [6:0] v);
      @(posedge clk);
      fire <= v;
      @(posedge clk);
      fire <= {v[6:5], 5'h00};
      repeat (8) @(posedge clk);
   endtask
   function automatic logic [7:0] fmap(input logic [6:0] v);
      fmap = {1'b0, v[4], v[5], v[6], v[3:0]};
   endfunction
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
         apb(1'b0, 12'(4 * i), 8'h00);
         chk(r, 32'h0);
      end
      exp = 8'h00;
      for (i = 0; i < 30; i = i + 1) begin
         f = 7'($random(seed));
         d = 8'($random(seed));
         fire_ev(f);
         exp = (exp & 8'h4f) | fmap(f);
         apb(1'b0, 12'h000, 8'h00);
         chk(r, {24'h0, exp});
         apb(1'b1, 12'h000, d);
         exp = exp & (d | 8'hb0);
         apb(1'b0, 12'h000, 8'h00);
         chk(r, {24'h0, exp});
      end
      fire_ev(7'h00);
      apb(1'b1, 12'h000, 8'h00);
      fork
         apb(1'b1, 12'h000, 8'h00);
         begin
            @(posedge clk);
            fire <= 7'h01;
            @(posedge clk);
            fire <= 7'h00;
         end
      join
      apb(1'b0, 12'h000, 8'h00);
      chk(r, 32'h1);
      // A write with its low byte lane off must leave the flags alone
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 8'h00);
      pstrb <= 4'hf;
      apb(1'b0, 12'h000, 8'h00);
      chk(r, 32'h1);
      apb(1'b0, 12'h020, 8'h00);
      chk({31'h0, serr}, 32'h1);
      chk(r, 32'h0);
      apb(1'b1, 12'h010, 8'h01);
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b0, 12'h00c, 8'h00);
      // Outputs that the access edge updates are looked at once settled
      @(negedge clk);
      chk({31'h0, irq_out}, 32'h0);
      fire_ev(7'h01);
      chk({31'h0, irq_out}, 32'h1);
      apb(1'b0, 12'h00c, 8'h00);
      chk(r, 32'h1);
      @(negedge clk);
      chk({31'h0, irq_out}, 32'h0);
      fire_ev(7'h10);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'b1, 12'h004, 8'h40);
      chk({31'h0, peripheral_irq}, 32'h0);
      apb(1'b1, 12'h008, 8'h80);
      @(negedge clk);
      chk({31'h0, peripheral_irq}, 32'h1);
      end_sim;
   end
endmodule
bind pfr_flag_reg pfr_flag_reg_monitor mon (
   .clk(clk),
   .reset_n(reset_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .flag_out(flag_out),
   .conv_done(conv_done),
   .sync_serial_done(sync_serial_done),
   .capcomp_event(capcomp_event),
   .timer_b_match(timer_b_match),
   .timer_a_overflow(timer_a_overflow),
   .rx_buffer_full(rx_buffer_full),
   .tx_buffer_empty(tx_buffer_empty)
);
`default_nettype wire
